// >>> inc/tsp_pkg.sv
// tsp_pkg: constants, register map, types and helpers of the tdm serial port framer
// assumes one 200 MHz AHB-Lite clock; serial pins are sampled as synchronous inputs
package tsp_pkg;
  localparam int TSP_WMAX = 16;
  localparam int TSP_ADDR_W = 8;
  localparam logic [7:0] TSP_A_CTRL = 8'h00;
  localparam logic [7:0] TSP_A_TX_FSDIV = 8'h04;
  localparam logic [7:0] TSP_A_RX_FSDIV = 8'h08;
  localparam logic [7:0] TSP_A_TX_CLKDIV = 8'h0C;
  localparam logic [7:0] TSP_A_RX_CLKDIV = 8'h10;
  localparam logic [7:0] TSP_A_TX_SLOTS = 8'h14;
  localparam logic [7:0] TSP_A_TX_DATA = 8'h18;
  localparam logic [7:0] TSP_A_RX_DATA = 8'h1C;
  localparam logic [7:0] TSP_A_STATUS = 8'h20;
  localparam logic [31:0] TSP_CTRL_RST = 32'h0000_0000;
  localparam logic [15:0] TSP_FSDIV_RST = 16'h03FF;
  localparam logic [15:0] TSP_CLKDIV_RST = 16'h0008;
  localparam logic [31:0] TSP_SLOTS_RST = 32'h0000_0000;
  localparam int TSP_B_TX_EN = 0;
  localparam int TSP_B_RX_EN = 1;
  localparam int TSP_B_TX_REQ = 2;
  localparam int TSP_B_RX_REQ = 3;
  localparam int TSP_B_TX_LOW = 4;
  localparam int TSP_B_RX_LOW = 5;
  localparam int TSP_B_TX_INT = 6;
  localparam int TSP_B_RX_INT = 7;
  localparam int TSP_B_TX_ALT = 8;
  localparam int TSP_B_RX_ALT = 9;
  localparam int TSP_B_EARLY = 10;
  localparam int TSP_B_MCM = 11;
  localparam int TSP_B_WLEN = 12;
  localparam int TSP_B_MFD = 16;
  localparam int TSP_B_TX_CM = 20;
  localparam int TSP_B_RX_CM = 22;
  localparam int TSP_S_TX_FULL = 0;
  localparam int TSP_S_RX_VALID = 1;
  localparam int TSP_S_RX_OVR = 2;
  localparam int TSP_S_TX_BUSY = 3;
  localparam int TSP_S_RX_BUSY = 4;
  typedef enum logic [1:0] {
    TSP_CLK_INT = 2'h0,
    TSP_CLK_BYPASS = 2'h1,
    TSP_CLK_HALF = 2'h2,
    TSP_CLK_RSVD = 2'h3
  } tsp_clk_mode_e;
  typedef enum logic [1:0] {
    TSP_IDLE = 2'h0,
    TSP_DELAY = 2'h1,
    TSP_SHIFT = 2'h3
  } tsp_eng_e;
  typedef struct packed {
    logic ext_clk;
    logic tx_fs;
    logic rx_fs;
    logic rx_data;
  } tsp_pin_in_s;
  typedef struct packed {
    logic tx_sck;
    logic rx_sck;
    logic tx_fs;
    logic tx_fs_oe_n;
    logic rx_fs;
    logic rx_fs_oe_n;
    logic tx_data;
    logic tx_data_oe_n;
  } tsp_pin_out_s;
  function automatic logic [4:0] tsp_word_len(input logic [3:0] f);
    return {1'b0, f} + 5'h01;
  endfunction
  function automatic logic [15:0] tsp_align(input logic [15:0] w, input logic [3:0] f);
    return w << (4'(TSP_WMAX - 1) - f);
  endfunction
endpackage

// >>> hdl/tsp_bitclk.sv
// tsp_bitclk: bit clock source, internal divider, bypass or half-rate recovery
// assumes ext_clk is already synchronous to hclk and slower than hclk / 2
`timescale 1ns/10ps
module tsp_bitclk
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire tsp_pkg::tsp_clk_mode_e mode,
  input wire logic [15:0] div,
  input wire logic ext_clk,
  input wire logic realign,
  output logic sck,
  output logic rise,
  output logic fall
);
  import tsp_pkg::*;
  typedef struct packed {
    logic ext;
    logic sck;
    logic [15:0] cnt;
  } tsp_bck_s;
  tsp_bck_s q;
  tsp_bck_s d;

  always_comb
  begin
    d = q;
    d.ext = ext_clk;
    case (mode)
      TSP_CLK_INT:
      begin
        // half period of div hclk cycles; 0 and 1 both give the fastest rate
        if ({1'b0, q.cnt} + 17'h00001 >= {1'b0, div})
        begin
          d.cnt = '0;
          d.sck = ~q.sck;
        end
        else
        begin
          d.cnt = q.cnt + 16'h0001;
        end
      end
      TSP_CLK_HALF:
      begin
        if (realign)
        begin
          d.sck = 1'b0;
        end
        else if (ext_clk && !q.ext)
        begin
          d.sck = ~q.sck;
        end
      end
      default:
      begin
        d.sck = ext_clk;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign sck = q.sck;
  assign rise = d.sck & ~q.sck;
  assign fall = ~d.sck & q.sck;
endmodule

// >>> hdl/tsp_port.sv
// tsp_port: tdm serial port framing engine with an AHB-Lite register slave
// assumes a single AHB-Lite master, word accesses only, pins synchronous to hclk
`timescale 1ns/10ps
module tsp_port
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire tsp_pkg::tsp_pin_in_s pin_i,
  output tsp_pkg::tsp_pin_out_s pin_o
);
  import tsp_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] tx_fsdiv;
    logic [15:0] rx_fsdiv;
    logic [15:0] tx_clkdiv;
    logic [15:0] rx_clkdiv;
    logic [31:0] tx_slots;
    logic [15:0] tx_hold;
    logic tx_hold_v;
    logic [15:0] rx_data;
    logic rx_v;
    logic rx_ovr;
    logic dph_wr;
    logic [7:0] dph_addr;
    logic [31:0] hrdata;
    tsp_eng_e tx_st;
    logic [15:0] tx_sh;
    logic [4:0] tx_cnt;
    logic [4:0] tx_slot;
    logic [3:0] tx_dly;
    logic [15:0] tx_fcnt;
    logic tx_fs_int;
    logic tx_fs_seen;
    logic tx_fs_prev;
    logic tx_drv;
    logic tx_dt;
    tsp_eng_e rx_st;
    logic [15:0] rx_sh;
    logic [4:0] rx_cnt;
    logic [3:0] rx_dly;
    logic [15:0] rx_fcnt;
    logic rx_fs_int;
    logic rx_fs_seen;
    logic rx_fs_prev;
    logic rx_started;
    logic rx_cont;
  } tsp_port_s;
  tsp_port_s q;
  tsp_port_s d;

  logic tx_rise, tx_fall, rx_rise, rx_fall, tx_sck, rx_sck;
  logic multichannel_enable, early, tx_req, rx_req, tx_alt, rx_alt, tx_int, rx_int;
  logic [3:0] wfield, multichannel_frame_delay;
  logic [4:0] wlen;
  logic tx_fs_act, rx_fs_act, tx_smp, rx_smp;
  logic tx_fs_now, rx_fs_now, tx_go, rx_go, tx_gen, rx_gen;
  logic tx_load, tx_new_frame, tx_sel, rx_first, rx_take;
  logic [4:0] tx_slot_n, rx_left;
  logic [15:0] rx_sh_n, tx_async_word;
  logic tx_async, rx_ovr_set;
  logic acc;

  assign multichannel_enable = q.ctrl[TSP_B_MCM];
  assign early = q.ctrl[TSP_B_EARLY];
  assign tx_req = q.ctrl[TSP_B_TX_REQ];
  assign rx_req = q.ctrl[TSP_B_RX_REQ];
  assign tx_alt = q.ctrl[TSP_B_TX_ALT];
  assign rx_alt = q.ctrl[TSP_B_RX_ALT];
  assign tx_int = q.ctrl[TSP_B_TX_INT];
  assign rx_int = q.ctrl[TSP_B_RX_INT];
  assign wfield = q.ctrl[TSP_B_WLEN +: 4];
  assign multichannel_frame_delay = q.ctrl[TSP_B_MFD +: 4];
  assign wlen = tsp_word_len(wfield);

  // internal sync bypasses the polarity inversion that an external one goes through
  assign tx_fs_act = tx_int ? q.tx_fs_int : (pin_i.tx_fs ^ q.ctrl[TSP_B_TX_LOW]);
  assign rx_fs_act = rx_int ? q.rx_fs_int : (pin_i.rx_fs ^ q.ctrl[TSP_B_RX_LOW]);
  assign tx_smp = early ? tx_rise : tx_fall;
  assign rx_smp = early ? rx_rise : rx_fall;

  tsp_bitclk u_tx_clk
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(tsp_clk_mode_e'(q.ctrl[TSP_B_TX_CM +: 2])),
    .div(q.tx_clkdiv),
    .ext_clk(pin_i.ext_clk),
    .realign(tx_fs_act & ~q.tx_fs_prev),
    .sck(tx_sck),
    .rise(tx_rise),
    .fall(tx_fall)
  );

  tsp_bitclk u_rx_clk
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .mode(tsp_clk_mode_e'(q.ctrl[TSP_B_RX_CM +: 2])),
    .div(q.rx_clkdiv),
    .ext_clk(pin_i.ext_clk),
    .realign(rx_fs_act & ~q.rx_fs_prev),
    .sck(rx_sck),
    .rise(rx_rise),
    .fall(rx_fall)
  );

  always_comb
  begin
    d = q;
    tx_load = 1'b0;
    tx_new_frame = 1'b0;
    tx_sel = 1'b0;
    tx_slot_n = q.tx_slot;
    rx_first = 1'b0;
    rx_take = 1'b0;
    rx_left = q.rx_cnt;
    rx_sh_n = q.rx_sh;
    // defaults keep the disabled paths free of latches
    tx_fs_now = 1'b0;
    tx_go = 1'b0;
    rx_fs_now = 1'b0;
    rx_go = 1'b0;
    rx_ovr_set = 1'b0;
    d.tx_fs_prev = tx_fs_act;
    d.rx_fs_prev = rx_fs_act;
    acc = hsel && htrans[1] && hready;
    // address phase: reads are answered from a flop in the data phase
    d.dph_wr = acc && hwrite;
    d.dph_addr = haddr[TSP_ADDR_W-1:0];
    d.hrdata = '0;
    if (acc && !hwrite)
    begin
      if (haddr[TSP_ADDR_W-1:0] == TSP_A_CTRL)
        d.hrdata = q.ctrl;
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_TX_FSDIV)
        d.hrdata = {16'h0000, q.tx_fsdiv};
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_RX_FSDIV)
        d.hrdata = {16'h0000, q.rx_fsdiv};
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_TX_CLKDIV)
        d.hrdata = {16'h0000, q.tx_clkdiv};
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_RX_CLKDIV)
        d.hrdata = {16'h0000, q.rx_clkdiv};
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_TX_SLOTS)
        d.hrdata = q.tx_slots;
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_TX_DATA)
        d.hrdata = {16'h0000, q.tx_hold};
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_RX_DATA)
      begin
        d.hrdata = {16'h0000, q.rx_data};
        d.rx_v = 1'b0;
      end
      else if (haddr[TSP_ADDR_W-1:0] == TSP_A_STATUS)
      begin
        d.hrdata[TSP_S_TX_FULL] = q.tx_hold_v;
        d.hrdata[TSP_S_RX_VALID] = q.rx_v;
        d.hrdata[TSP_S_RX_OVR] = q.rx_ovr;
        d.hrdata[TSP_S_TX_BUSY] = q.tx_st != TSP_IDLE;
        d.hrdata[TSP_S_RX_BUSY] = q.rx_st != TSP_IDLE;
      end
    end

    // transmit side: words leave on bit clock rising edges
    tx_gen = tx_req || (q.tx_st == TSP_IDLE && q.tx_hold_v);
    if (!q.ctrl[TSP_B_TX_EN])
    begin
      d.tx_st = TSP_IDLE;
      d.tx_drv = 1'b0;
      d.tx_fs_int = 1'b0;
      d.tx_fs_seen = 1'b0;
      d.tx_fcnt = '0;
    end
    else
    begin
      if (early ? tx_fall : tx_rise)
      begin
        d.tx_fcnt = (q.tx_fcnt >= q.tx_fsdiv) ? '0 : q.tx_fcnt + 16'h0001;
        d.tx_fs_int = (d.tx_fcnt == '0) && tx_gen && tx_int;
      end
      tx_fs_now = tx_int ? d.tx_fs_int : tx_fs_act;
      tx_go = tx_alt ? tx_fs_now : q.tx_fs_seen;
      if (tx_rise)
      begin
        case (q.tx_st)
          TSP_IDLE:
          begin
            tx_new_frame = tx_go;
          end
          TSP_DELAY:
          begin
            if (q.tx_dly == '0)
              tx_load = 1'b1;
            else
              d.tx_dly = q.tx_dly - 4'h1;
          end
          default:
          begin
            if (q.tx_cnt == '0)
            begin
              if (tx_go)
                tx_new_frame = 1'b1;
              else if (multichannel_enable || (!tx_req && q.tx_hold_v))
              begin
                tx_load = 1'b1;
                tx_slot_n = q.tx_slot + 5'h01;
              end
              else
              begin
                d.tx_st = TSP_IDLE;
                d.tx_drv = 1'b0;
              end
            end
            else
            begin
              d.tx_cnt = q.tx_cnt - 5'h01;
              d.tx_sh = q.tx_sh << 1;
              d.tx_dt = d.tx_sh[TSP_WMAX-1];
            end
          end
        endcase
        if (tx_new_frame)
        begin
          d.tx_fs_seen = 1'b0;
          tx_slot_n = '0;
          if (multichannel_enable && multichannel_frame_delay != '0)
          begin
            d.tx_st = TSP_DELAY;
            d.tx_dly = multichannel_frame_delay - 4'h1;
            d.tx_drv = 1'b0;
          end
          else
          begin
            tx_load = 1'b1;
          end
        end
        if (tx_load)
        begin
          d.tx_st = TSP_SHIFT;
          d.tx_slot = tx_slot_n;
          d.tx_cnt = wlen - 5'h01;
          tx_sel = !multichannel_enable || q.tx_slots[tx_slot_n];
          d.tx_drv = tx_sel && q.tx_hold_v;
          d.tx_sh = d.tx_drv ? tsp_align(q.tx_hold, wfield) : '0;
          d.tx_dt = d.tx_sh[TSP_WMAX-1];
          if (d.tx_drv)
            d.tx_hold_v = 1'b0;
        end
      end
      if (tx_smp && tx_fs_act)
        d.tx_fs_seen = 1'b1;
    end

    // receive side: bits are taken on bit clock falling edges
    rx_gen = rx_req || (q.rx_st == TSP_IDLE && !q.rx_started);
    if (!q.ctrl[TSP_B_RX_EN])
    begin
      d.rx_st = TSP_IDLE;
      d.rx_fs_int = 1'b0;
      d.rx_fs_seen = 1'b0;
      d.rx_started = 1'b0;
      d.rx_cont = 1'b0;
      d.rx_fcnt = '0;
    end
    else
    begin
      if (early ? rx_fall : rx_rise)
      begin
        d.rx_fcnt = (q.rx_fcnt >= q.rx_fsdiv) ? '0 : q.rx_fcnt + 16'h0001;
        d.rx_fs_int = (d.rx_fcnt == '0) && rx_gen && rx_int;
      end
      rx_fs_now = rx_int ? q.rx_fs_int : rx_fs_act;
      rx_go = rx_alt ? rx_fs_now : q.rx_fs_seen;
      if (rx_fall)
      begin
        case (q.rx_st)
          TSP_IDLE:
          begin
            if (rx_go && (rx_req || !q.rx_started))
            begin
              d.rx_started = 1'b1;
              if (multichannel_enable && multichannel_frame_delay != '0)
              begin
                d.rx_st = TSP_DELAY;
                d.rx_dly = multichannel_frame_delay - 4'h1;
              end
              else
              begin
                rx_first = 1'b1;
              end
            end
            else if (q.rx_cont)
            begin
              rx_first = 1'b1;
            end
          end
          TSP_DELAY:
          begin
            if (q.rx_dly == '0)
              rx_first = 1'b1;
            else
              d.rx_dly = q.rx_dly - 4'h1;
          end
          default:
          begin
            rx_take = 1'b1;
            rx_sh_n = {q.rx_sh[TSP_WMAX-2:0], pin_i.rx_data};
            rx_left = q.rx_cnt - 5'h01;
          end
        endcase
        if (rx_first)
        begin
          d.rx_fs_seen = 1'b0;
          rx_take = 1'b1;
          rx_sh_n = {{(TSP_WMAX-1){1'b0}}, pin_i.rx_data};
          rx_left = wlen - 5'h01;
        end
        if (rx_take)
        begin
          d.rx_sh = rx_sh_n;
          d.rx_cnt = rx_left;
          d.rx_st = TSP_SHIFT;
          if (rx_left == '0)
          begin
            d.rx_st = TSP_IDLE;
            d.rx_cont = multichannel_enable || !rx_req;
            d.rx_data = rx_sh_n;
            rx_ovr_set = d.rx_v;
            if (d.rx_v)
              d.rx_ovr = 1'b1;
            d.rx_v = 1'b1;
          end
        end
      end
      if (rx_smp && rx_fs_act)
        d.rx_fs_seen = 1'b1;
    end

    // data phase writes come last so a new word is never lost to a load
    if (q.dph_wr)
    begin
      if (q.dph_addr == TSP_A_CTRL)
        d.ctrl = hwdata;
      else if (q.dph_addr == TSP_A_TX_FSDIV)
        d.tx_fsdiv = hwdata[15:0];
      else if (q.dph_addr == TSP_A_RX_FSDIV)
        d.rx_fsdiv = hwdata[15:0];
      else if (q.dph_addr == TSP_A_TX_CLKDIV)
        d.tx_clkdiv = hwdata[15:0];
      else if (q.dph_addr == TSP_A_RX_CLKDIV)
        d.rx_clkdiv = hwdata[15:0];
      else if (q.dph_addr == TSP_A_TX_SLOTS)
        d.tx_slots = hwdata;
      else if (q.dph_addr == TSP_A_TX_DATA)
      begin
        d.tx_hold = hwdata[15:0];
        d.tx_hold_v = 1'b1;
      end
      // a fresh overrun wins over a clear in the same cycle
      else if (q.dph_addr == TSP_A_STATUS && hwdata[TSP_S_RX_OVR] && !rx_ovr_set)
        d.rx_ovr = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q <= '0;
      q.ctrl <= TSP_CTRL_RST;
      q.tx_fsdiv <= TSP_FSDIV_RST;
      q.rx_fsdiv <= TSP_FSDIV_RST;
      q.tx_clkdiv <= TSP_CLKDIV_RST;
      q.rx_clkdiv <= TSP_CLKDIV_RST;
      q.tx_slots <= TSP_SLOTS_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // external alternate sync: first bit follows the pin without a clock edge
  assign tx_async_word = tsp_align(q.tx_hold, wfield);
  assign tx_async = q.ctrl[TSP_B_TX_EN] && tx_alt && !tx_int && q.tx_st == TSP_IDLE
    && tx_fs_act && q.tx_hold_v && (!multichannel_enable || q.tx_slots[0]);

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata;
  assign pin_o.tx_sck = tx_sck;
  assign pin_o.rx_sck = rx_sck;
  assign pin_o.tx_fs = q.tx_fs_int ^ q.ctrl[TSP_B_TX_LOW];
  assign pin_o.tx_fs_oe_n = ~tx_int;
  assign pin_o.rx_fs = q.rx_fs_int ^ q.ctrl[TSP_B_RX_LOW];
  assign pin_o.rx_fs_oe_n = ~rx_int;
  assign pin_o.tx_data = tx_async ? tx_async_word[TSP_WMAX-1] : q.tx_dt;
  assign pin_o.tx_data_oe_n = ~(q.tx_drv | tx_async);
endmodule

// >>> verif/tsp_port_props.sv
// tsp_port_props: concurrent checks on the top ports of the tdm serial port framer
// assumes one slave on the bus with hready tied to hreadyout; bound to tsp_port below
`timescale 1ns/10ps
module tsp_port_props
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire tsp_pkg::tsp_pin_in_s pin_i,
  input wire tsp_pkg::tsp_pin_out_s pin_o
);
  import tsp_pkg::*;
  logic ap_q;
  logic wr_q;
  logic ext_q;
  logic [7:0] a_q;
  logic [3:0] age_q;
  logic [3:0] ext_age_q;
  logic [31:0] cfg_q [6];
  logic [31:0] ctl;
  logic [31:0] msk;
  assign ctl = cfg_q[0];
  // upper ctrl bits are unassigned, so only the defined fields are compared
  assign msk = (a_q == TSP_A_CTRL) ? 32'h00FF_FFFF :
    (a_q == TSP_A_TX_SLOTS) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      ext_q <= 1'b0;
      a_q <= 8'h00;
      age_q <= 4'h0;
      ext_age_q <= 4'hF;
      cfg_q[0] <= 32'h0000_0000;
      cfg_q[1] <= 32'h0000_03FF;
      cfg_q[2] <= 32'h0000_03FF;
      cfg_q[3] <= 32'h0000_0008;
      cfg_q[4] <= 32'h0000_0008;
      cfg_q[5] <= 32'h0000_0000;
    end
    else
    begin
      ap_q <= hsel && htrans[1] && hready;
      wr_q <= hwrite;
      a_q <= haddr[7:0];
      ext_q <= pin_i.ext_clk;
      ext_age_q <= (pin_i.ext_clk && !ext_q) ? 4'h0 : ext_age_q + {3'h0, ext_age_q != 4'hF};
      age_q <= (ap_q && wr_q && a_q == TSP_A_CTRL) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      if (ap_q && wr_q && a_q <= TSP_A_TX_SLOTS)
        cfg_q[a_q[4:2]] <= hwdata;
    end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_rd_data;
    ap_q && !wr_q;
  endsequence
  // pins lag a ctrl write by a few cycles, so checks wait for it to settle
  sequence s_cfg_settled;
    age_q > 4'h4;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_rdata_idle: assert property (!(ap_q && !wr_q) |-> hrdata == 32'h0000_0000)
    else $error("read data not zero outside a read data phase");
  a_cfg_readback: assert property (s_rd_data ##0 (a_q <= TSP_A_TX_SLOTS)
    |-> (hrdata & msk) == (cfg_q[a_q[4:2]] & msk))
    else $error("config register reads back a wrong value");
  a_unmapped_zero: assert property (s_rd_data ##0 (a_q > TSP_A_STATUS) |-> hrdata == 32'h0)
    else $error("unmapped address reads non zero");
  a_fs_oe_ctrl: assert property (s_cfg_settled |->
    pin_o.tx_fs_oe_n == !ctl[TSP_B_TX_INT] && pin_o.rx_fs_oe_n == !ctl[TSP_B_RX_INT])
    else $error("frame sync drive enable differs from ctrl");
  a_fs_idle_level: assert property (s_cfg_settled ##0
    (ctl[TSP_B_TX_INT] && !ctl[TSP_B_TX_EN]) |-> pin_o.tx_fs == ctl[TSP_B_TX_LOW])
    else $error("idle frame sync level wrong for polarity");
  a_tx_released: assert property (s_cfg_settled ##0 !ctl[TSP_B_TX_EN] |-> pin_o.tx_data_oe_n)
    else $error("data pin driven while transmit disabled");
  a_sck_follow: assert property (s_cfg_settled ##0
    (ctl[TSP_B_RX_CM +: 2] != 2'h0 && $rose(pin_o.rx_sck)) |-> ext_age_q < 4'h6)
    else $error("recovered bit clock rose without an input clock rise");
endmodule

bind tsp_port tsp_port_props i_props
(
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_i(pin_i), .pin_o(pin_o)
);

// >>> verif/tsp_tdm_far.sv
// tsp_tdm_far: behavioural far end of the tdm bus: clock source, framer and slot listener
// assumes hclk is much faster than the bit clock; lines change just after a rising hclk edge
`timescale 1ns/10ps
module tsp_tdm_far
(
  input wire logic hclk,
  input wire tsp_pkg::tsp_pin_out_s pin_o,
  output tsp_pkg::tsp_pin_in_s pin_i
);
  import tsp_pkg::*;
  initial
  begin
    pin_i = '0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic set_idle(input logic low);
    pin_i.tx_fs <= low;
    pin_i.rx_fs <= low;
  endtask
  // clock runs only inside these tasks and stands low between them
  task automatic clocks(input int n, input int hp);
    repeat (n)
    begin
      tick(hp);
      pin_i.ext_clk <= 1'b1;
      tick(hp);
      pin_i.ext_clk <= 1'b0;
    end
  endtask
  // one sync a bit clock ahead of the msb, then the word, then one idle clock
  task automatic rx_frame(input logic [15:0] w, input int len, input logic low);
    for (int i = -1; i <= len; i++)
    begin
      tick(4);
      pin_i.ext_clk <= 1'b1;
      pin_i.rx_fs <= (i < 0) ^ low;
      pin_i.rx_data <= (i >= 0 && i < len) ? w[len - 1 - i] : ~pin_i.rx_data;
      tick(4);
      pin_i.ext_clk <= 1'b0;
    end
  endtask
  // listens at bit clock falls after the first sync; counts released bits apart
  task automatic catch(input int nbits, input logic low, output logic [15:0] w, output int rel);
    logic sq;
    logic go;
    int got;
    sq = 1'b0;
    go = 1'b0;
    got = 0;
    w = '0;
    rel = 0;
    for (int k = 0; k < 4000 && got < nbits; k++)
    begin
      @(posedge hclk);
      if (sq && !pin_o.tx_sck)
      begin
        if (go && pin_o.tx_data_oe_n !== 1'b0)
          rel++;
        else if (go)
          w = {w[14:0], pin_o.tx_data};
        if (go)
          got++;
        go = go | (pin_o.tx_fs === !low);
      end
      sq = pin_o.tx_sck;
    end
    // a frame that never completes spoils the release count on purpose
    if (got < nbits)
      rel = -1;
  endtask
endmodule

// >>> verif/tb.sv
// tb: register-level tests of the tdm serial port framer through its AHB-Lite slave
// assumes the far end model drives the serial inputs and the checker is bound to the port
`timescale 1ns/10ps
module tb;
  import tsp_pkg::*;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  tsp_pin_in_s pin_i;
  tsp_pin_out_s pin_o;
  int n_errors;
  int n_tests;
  int n_rise;
  int rel;
  logic rsck_q;
  logic [31:0] rd;
  logic [31:0] ctl;
  logic [15:0] w;
  logic [31:0] rst_tab [6] = '{32'h0, 32'h3FF, 32'h3FF, 32'h8, 32'h8, 32'h0};
  assign hready = hreadyout;
  tsp_port i_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_i(pin_i), .pin_o(pin_o)
  );
  tsp_tdm_far i_far
  (
    .hclk(hclk), .pin_o(pin_o), .pin_i(pin_i)
  );
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    rsck_q <= pin_o.rx_sck;
    if (pin_o.rx_sck === 1'b1 && rsck_q === 1'b0)
      n_rise++;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // a hung bus ends the run; it never waits unbounded
  task automatic wait_rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hready !== 1'b1 && k < 64);
    if (hready !== 1'b1)
    begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic ahb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb_xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    ahb_xfer(1'b0, a, 32'h0, q);
    check(what, q, exp);
  endtask
  initial
  begin
    n_errors = 0;
    n_tests = 0;
    n_rise = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++)
      rd_chk("reset value", 8'(i * 4), rst_tab[i]);
    ahb_wr(8'h40, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h40, 32'h0);
    ahb_wr(TSP_A_TX_CLKDIV, 32'h2);
    ahb_wr(TSP_A_TX_FSDIV, 32'h1F);
    // polarity 0 with 4-bit words, then polarity 1 with 8-bit words
    for (int p = 0; p < 2; p++)
    begin
      i_far.set_idle(p[0]);
      ctl = (32'(p) << TSP_B_TX_LOW) | (32'(3 + 4 * p) << TSP_B_WLEN) | 32'h44;
      ahb_wr(TSP_A_CTRL, ctl);
      repeat (8) @(posedge hclk);
      ahb_wr(TSP_A_CTRL, ctl | 32'h1);
      ahb_wr(TSP_A_TX_DATA, p ? 32'hA5 : 32'hA);
      i_far.catch(4 + 4 * p, p[0], w, rel);
      check("tx word", {16'h0, w}, p ? 32'hA5 : 32'hA);
      check("tx released bits", 32'(rel), 32'h0);
      ahb_wr(TSP_A_CTRL, 32'h0);
    end
    // only slot 1 selected: slot 0 must float, the word lands in slot 1
    i_far.set_idle(1'b0);
    ahb_wr(TSP_A_TX_SLOTS, 32'h2);
    rd_chk("slot select", TSP_A_TX_SLOTS, 32'h2);
    ahb_wr(TSP_A_CTRL, 32'h0000_3845);
    ahb_wr(TSP_A_TX_DATA, 32'h9);
    i_far.catch(8, 1'b0, w, rel);
    check("slot word", {16'h0, w}, 32'h9);
    check("slot released bits", 32'(rel), 32'h4);
    ahb_wr(TSP_A_CTRL, 32'h0);
    for (int p = 0; p < 2; p++)
    begin
      i_far.set_idle(p[0]);
      ctl = (32'(TSP_CLK_BYPASS) << TSP_B_RX_CM) | (32'h7 << TSP_B_WLEN) | 32'hA;
      ahb_wr(TSP_A_CTRL, ctl | (32'(p) << TSP_B_RX_LOW));
      i_far.rx_frame(p ? 16'h5C : 16'hC3, 8, p[0]);
      ahb_xfer(1'b0, TSP_A_STATUS, 32'h0, rd);
      check("rx valid", {30'h0, rd[2:1]}, 32'h1);
      rd_chk("rx word", TSP_A_RX_DATA, p ? 32'h5C : 32'hC3);
      ahb_xfer(1'b0, TSP_A_STATUS, 32'h0, rd);
      check("rx valid cleared", {31'h0, rd[1]}, 32'h0);
      ahb_wr(TSP_A_CTRL, 32'h0);
    end
    // unframed: one sync, two words back to back; the unread first one overruns
    i_far.set_idle(1'b0);
    ahb_wr(TSP_A_CTRL, (32'(TSP_CLK_BYPASS) << TSP_B_RX_CM) | (32'h7 << TSP_B_WLEN) | 32'h2);
    i_far.rx_frame(16'hC35C, 16, 1'b0);
    ahb_xfer(1'b0, TSP_A_STATUS, 32'h0, rd);
    check("burst status", {30'h0, rd[2:1]}, 32'h3);
    rd_chk("burst word", TSP_A_RX_DATA, 32'h5C);
    ahb_wr(TSP_A_STATUS, 32'h1 << TSP_S_RX_OVR);
    ahb_xfer(1'b0, TSP_A_STATUS, 32'h0, rd);
    check("burst status cleared", {30'h0, rd[2:1]}, 32'h0);
    ahb_wr(TSP_A_CTRL, 32'h0);
    // codes 1..3: bypass, half-rate recovery, bypass again
    for (int m = 1; m < 4; m++)
    begin
      ahb_wr(TSP_A_CTRL, (32'(m) << TSP_B_RX_CM) | 32'hA);
      repeat (8) @(posedge hclk);
      n_rise = 0;
      i_far.clocks(8, 8);
      repeat (12) @(posedge hclk);
      check("rx bit clock rises", 32'(n_rise), m == 2 ? 32'h4 : 32'h8);
    end
    ahb_wr(TSP_A_CTRL, 32'h0);
    give_verdict();
  end
endmodule
